//--- shared/dtc_pkg.sv
// Purpose: constants shared by the dual 8-bit timer/counter block
// Assumes: byte-wide CPU memory port, one 20 MHz peripheral clock
// Notes:   per-unit tables are indexed [0] = unit A, [1] = unit B
`default_nettype none
package dtc_pkg;
	localparam int          DTC_UNITS      = 2;
	localparam int          DTC_CLK_HZ     = 20_000_000;
	// register addresses, unit B in the upper entry
	localparam logic [1:0][15:0] DTC_MODE_ADDR  = {16'hFF69, 16'hFF68};
	localparam logic [1:0][15:0] DTC_CSEL_ADDR  = {16'hFF57, 16'hFF6C};
	localparam logic [1:0][15:0] DTC_CNT_ADDR   = {16'hFF61, 16'hFF60};
	localparam logic [1:0][15:0] DTC_CMP_ADDR   = {16'hFF65, 16'hFF64};
	// mode control fields
	localparam int          DTC_EN_BIT     = 7;
	localparam int          DTC_PWM_BIT    = 6;
	localparam int          DTC_CASC_BIT   = 4;
	localparam int          DTC_SET_BIT    = 3;
	localparam int          DTC_CLR_BIT    = 2;
	localparam int          DTC_INV_BIT    = 1;
	localparam int          DTC_TOE_BIT    = 0;
	localparam logic [1:0][7:0] DTC_MODE_MASK = {8'hD3, 8'hC3};
	localparam logic [7:0]  DTC_CSEL_MASK  = 8'h07;
	localparam logic [1:0]  DTC_FF_KEEP    = 2'h0;
	localparam logic [1:0]  DTC_FF_CLR     = 2'h1;
	localparam logic [1:0]  DTC_FF_SET     = 2'h2;
	// reset and count values
	localparam logic [7:0]  DTC_RST_BYTE   = 8'h00;
	localparam logic [7:0]  DTC_CNT_ZERO   = 8'h00;
	localparam logic [7:0]  DTC_CNT_ONE    = 8'h01;
	localparam logic [7:0]  DTC_CNT_MAX    = 8'hFF;
	// count clock codes
	localparam logic [2:0]  DTC_CS_FALL    = 3'h0;
	localparam logic [2:0]  DTC_CS_RISE    = 3'h1;
	localparam logic [2:0]  DTC_CS_DIV4    = 3'h2;
	localparam logic [2:0]  DTC_CS_DIV8    = 3'h3;
	localparam logic [2:0]  DTC_CS_DIV16   = 3'h4;
	localparam logic [2:0]  DTC_CS_DIV32   = 3'h5;
	localparam logic [2:0]  DTC_CS_DIV128  = 3'h6;
	localparam logic [2:0]  DTC_CS_DIV512  = 3'h7;
	// prescaler terminal masks
	localparam int          DTC_PRE_W      = 9;
	localparam logic [8:0]  DTC_PRE_ZERO   = 9'h000;
	localparam logic [8:0]  DTC_PRE_ONE    = 9'h001;
	localparam logic [8:0]  DTC_MASK_DIV4  = 9'h003;
	localparam logic [8:0]  DTC_MASK_DIV8  = 9'h007;
	localparam logic [8:0]  DTC_MASK_DIV16 = 9'h00F;
	localparam logic [8:0]  DTC_MASK_DIV32 = 9'h01F;
	localparam logic [8:0]  DTC_MASK_DIV128 = 9'h07F;
	localparam logic [8:0]  DTC_MASK_DIV512 = 9'h1FF;
endpackage
`default_nettype wire

//--- design/dtc_clock_sel.sv
// Purpose: count clock select for one unit: event pin edge or divided clock
// Assumes: event pin is asynchronous to clk
// Notes:   tick is a one-cycle pulse; prescaler is held at zero while disabled
`default_nettype none
module dtc_clock_sel
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       enable,
	input  wire logic [2:0] clock_code,
	// event pin
	input  wire logic       event_pin,
	// count clock
	output logic            tick
);
	typedef struct packed {
		logic [DTC_PRE_W-1:0] pre;
		logic [2:0]           sync;
		logic                 level;
		logic                 tick;
	} dtc_csel_state_t;

	dtc_csel_state_t s;
	dtc_csel_state_t n;

	function automatic logic [DTC_PRE_W-1:0] dtc_div_mask(input logic [2:0] code);
		unique case (code)
			DTC_CS_FALL:   dtc_div_mask = DTC_PRE_ZERO;
			DTC_CS_RISE:   dtc_div_mask = DTC_PRE_ZERO;
			DTC_CS_DIV4:   dtc_div_mask = DTC_MASK_DIV4;
			DTC_CS_DIV8:   dtc_div_mask = DTC_MASK_DIV8;
			DTC_CS_DIV16:  dtc_div_mask = DTC_MASK_DIV16;
			DTC_CS_DIV32:  dtc_div_mask = DTC_MASK_DIV32;
			DTC_CS_DIV128: dtc_div_mask = DTC_MASK_DIV128;
			DTC_CS_DIV512: dtc_div_mask = DTC_MASK_DIV512;
		endcase
	endfunction

	always_comb begin
		logic lvl;
		logic [DTC_PRE_W-1:0] msk;
		lvl = s.level;
		msk = dtc_div_mask(clock_code);
		n = s;
		// three-stage synchroniser; level accepted once stages two and three agree
		n.sync = {s.sync[1:0], event_pin};
		if (s.sync[1] == s.sync[2]) begin
			lvl = s.sync[2];
		end
		n.level = lvl;
		// [R8] prescaler halted
		n.pre = enable ? DTC_PRE_W'(s.pre + DTC_PRE_ONE) : DTC_PRE_ZERO;
		// [R18] count clock choice
		if (!enable) begin
			n.tick = 1'b0;
		end else if (clock_code == DTC_CS_FALL) begin
			n.tick = s.level & ~lvl;
		end else if (clock_code == DTC_CS_RISE) begin
			n.tick = lvl & ~s.level;
		end else begin
			n.tick = ((s.pre & msk) == msk);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tick = s.tick;
endmodule
`default_nettype wire

//--- design/dtc_timer.sv
// Purpose: two 8-bit timer/counters with cascade, interval, square wave and PWM
// Assumes: single-cycle CPU reads and writes on a byte-wide memory port
// Notes:   read data appears one cycle after the read strobe
`default_nettype none
// Behaviour
// [R1] counts step by one on each selected count tick; software cannot write them
// [R2] reading a running count defers that tick and returns the held value
// [R3] count zeroes on reset, on stop, and on match in interval mode
// [R4] in cascade, stopping unit A zeroes both counts
// [R5] a count equal to its compare raises the match pulse, never in PWM mode
// [R6] compare registers take any byte, also while counting
// [R7] software changes cascaded compare values only while stopped
// [R8] mode bit 7 runs the unit; clearing it zeroes count and halts prescaler
// [R9] mode bit 6 picks interval (0) or free-running PWM (1)
// [R10] unit B mode bit 4 joins both units into one 16-bit counter
// [R11] mode bits 3..2 on write: 01 clears, 10 sets output flop, 11 ignored
// [R12] output set and clear bits always read back as zero
// [R13] mode bit 1: toggle on match outside PWM; low active level in PWM
// [R14] mode bit 0 enables the timer output pin driver
// [R15] stopping a PWM unit drives its output to the inactive level
// [R16] both mode control registers reset to zero
// [R17] both clock select registers reset to zero
// [R18] clock codes: pin fall, pin rise, clock divided by 4..512
// [R19] clock select bits 7..3 hold zero
// [R20] software changes the clock select only while stopped
// [R21] interval match clears the count together with the match pulse, keeps running
// [R22] software sets up interval mode first, then sets the run bit
// [R23] in cascade, software starts unit B before unit A
// [R24] cascade double match pulses unit A and clears both counts
// [R25] toggle on match gives a square wave with half-period equal to interval
// [R26] PWM output inactive until first wrap, active until compare, then inactive
// [R27] in cascade unit B steps on each unit A wrap, ignoring its clock select
module dtc_timer
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// cpu memory port
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_wr,
	input  wire logic        cpu_rd,
	input  wire logic [7:0]  cpu_wdata,
	output logic      [7:0]  cpu_rdata,
	// event pins
	input  wire logic        unit_a_event_input,
	input  wire logic        unit_b_event_input,
	// timer outputs
	output logic             unit_a_timer_output,
	output logic             unit_a_timer_output_en,
	output logic             unit_b_timer_output,
	output logic             unit_b_timer_output_en,
	// match interrupt requests
	output logic             unit_a_match_irq,
	output logic             unit_b_match_irq
);
	typedef struct packed {
		logic [1:0][7:0] cnt;
		logic [1:0][7:0] cmp;
		logic [1:0][7:0] mode;
		logic [1:0][2:0] csel;
		logic [1:0]      tff;
		logic [1:0]      pin;
		logic [1:0]      oe;
		logic [1:0]      irq;
		logic [1:0]      pend;
		logic [7:0]      rdata;
	} dtc_state_t;

	dtc_state_t s;
	dtc_state_t n;

	logic [1:0] tick_raw;
	logic [1:0] raw;
	logic [1:0] eff;
	logic [1:0] hold;
	logic [1:0] en;
	logic [1:0] pwm;
	logic [1:0] inv;
	logic [1:0] match;
	logic       cascade;
	logic       both;
	logic       a_wrap;

	function automatic logic [7:0] dtc_step(input logic [7:0] v);
		dtc_step = 8'(v + DTC_CNT_ONE);
	endfunction

	dtc_clock_sel u_csel_a (
		.clk        (clk),
		.rst_n      (rst_n),
		.enable     (en[0]),
		.clock_code (s.csel[0]),
		.event_pin  (unit_a_event_input),
		.tick       (tick_raw[0])
	);

	dtc_clock_sel u_csel_b (
		.clk        (clk),
		.rst_n      (rst_n),
		.enable     (en[1]),
		.clock_code (s.csel[1]),
		.event_pin  (unit_b_event_input),
		.tick       (tick_raw[1])
	);

	// [R8] run bits
	assign en[0]    = s.mode[0][DTC_EN_BIT];
	assign en[1]    = s.mode[1][DTC_EN_BIT];
	// [R9] mode selection
	assign pwm[0]   = s.mode[0][DTC_PWM_BIT];
	assign pwm[1]   = s.mode[1][DTC_PWM_BIT];
	assign inv[0]   = s.mode[0][DTC_INV_BIT];
	assign inv[1]   = s.mode[1][DTC_INV_BIT];
	// [R10] cascade selection
	assign cascade  = s.mode[1][DTC_CASC_BIT];
	assign match[0] = (s.cnt[0] == s.cmp[0]);
	assign match[1] = (s.cnt[1] == s.cmp[1]);
	assign both     = match[0] & match[1];
	// [R2] read hold-off
	assign hold[0]  = cpu_rd & (cpu_addr == DTC_CNT_ADDR[0]) & en[0];
	assign hold[1]  = cpu_rd & (cpu_addr == DTC_CNT_ADDR[1]) & en[1];
	assign raw[0]   = tick_raw[0];
	assign eff[0]   = en[0] & (raw[0] | s.pend[0]) & ~hold[0];
	// [R27] unit B steps on unit A wrap
	assign a_wrap   = eff[0] & (s.cnt[0] == DTC_CNT_MAX) & ~(cascade & both & ~pwm[0]);
	assign raw[1]   = cascade ? a_wrap : tick_raw[1];
	assign eff[1]   = en[1] & (raw[1] | s.pend[1]) & ~hold[1];

	always_comb begin
		n = s;
		n.irq = '0;
		for (int u = 0; u < DTC_UNITS; u++) begin
			if (!en[u]) begin
				// [R3] stop clears count
				n.cnt[u] = DTC_CNT_ZERO;
				n.pend[u] = 1'b0;
				// [R15] stop forces inactive
				if (pwm[u]) begin
					n.tff[u] = 1'b0;
				end
			end else begin
				n.pend[u] = (raw[u] | s.pend[u]) & hold[u];
				if (eff[u]) begin
					if (pwm[u]) begin
						// [R26] active from wrap to compare
						n.cnt[u] = dtc_step(s.cnt[u]);
						if (s.cnt[u] == DTC_CNT_MAX) begin
							n.tff[u] = 1'b1;
						end else if (match[u]) begin
							n.tff[u] = 1'b0;
						end
					end else if (cascade) begin
						// [R1] count step
						n.cnt[u] = dtc_step(s.cnt[u]);
						// [R24] 16-bit match
						if (u == 0 && both) begin
							n.cnt[u] = DTC_CNT_ZERO;
							n.irq[u] = 1'b1;
							if (inv[u]) begin
								n.tff[u] = ~s.tff[u];
							end
						end
						if (u == 1 && match[u]) begin
							n.irq[u] = 1'b1;
						end
					end else if (match[u]) begin
						// [R21] clear with match pulse
						n.cnt[u] = DTC_CNT_ZERO;
						// [R5] match pulse
						n.irq[u] = 1'b1;
						// [R25] square wave toggle
						if (inv[u]) begin
							n.tff[u] = ~s.tff[u];
						end
					end else begin
						n.cnt[u] = dtc_step(s.cnt[u]);
					end
				end
			end
		end
		// [R4] cascade stop clears upper
		if (cascade && !en[0]) begin
			n.cnt[1] = DTC_CNT_ZERO;
		end
		// [R24] upper byte clears too
		if (cascade && eff[0] && both && !pwm[0]) begin
			n.cnt[1] = DTC_CNT_ZERO;
		end
		if (cpu_wr) begin
			for (int u = 0; u < DTC_UNITS; u++) begin
				if (cpu_addr == DTC_MODE_ADDR[u]) begin
					// [R12] set and clear bits not stored
					n.mode[u] = cpu_wdata & DTC_MODE_MASK[u];
					// [R15] stop written in PWM drops the flop, also when the mode bit goes
					if (pwm[u] && !cpu_wdata[DTC_EN_BIT]) begin
						n.tff[u] = 1'b0;
					end
					// [R11] output flop set/clear
					unique case (cpu_wdata[DTC_SET_BIT:DTC_CLR_BIT])
						DTC_FF_KEEP: n.tff[u] = n.tff[u];
						DTC_FF_CLR:  n.tff[u] = 1'b0;
						DTC_FF_SET:  n.tff[u] = 1'b1;
						default:     n.tff[u] = n.tff[u];
					endcase
					// [R8] stop clears count
					if (!cpu_wdata[DTC_EN_BIT]) begin
						n.cnt[u] = DTC_CNT_ZERO;
						if (u == 0 && cascade) begin
							n.cnt[1] = DTC_CNT_ZERO;
						end
					end
				end
				// [R6] compare always writable
				if (cpu_addr == DTC_CMP_ADDR[u]) begin
					n.cmp[u] = cpu_wdata;
				end
				// [R19] upper bits dropped
				if (cpu_addr == DTC_CSEL_ADDR[u]) begin
					n.csel[u] = cpu_wdata[2:0];
				end
			end
		end
		if (cpu_rd) begin
			n.rdata = DTC_RST_BYTE;
			for (int u = 0; u < DTC_UNITS; u++) begin
				if (cpu_addr == DTC_CNT_ADDR[u]) begin
					n.rdata = s.cnt[u];
				end
				if (cpu_addr == DTC_CMP_ADDR[u]) begin
					n.rdata = s.cmp[u];
				end
				if (cpu_addr == DTC_MODE_ADDR[u]) begin
					n.rdata = s.mode[u];
				end
				if (cpu_addr == DTC_CSEL_ADDR[u]) begin
					n.rdata = 8'(s.csel[u]);
				end
			end
		end
		for (int u = 0; u < DTC_UNITS; u++) begin
			// [R13] PWM active level
			n.pin[u] = n.tff[u] ^ (n.mode[u][DTC_PWM_BIT] & n.mode[u][DTC_INV_BIT]);
			// [R14] output gating
			n.oe[u] = n.mode[u][DTC_TOE_BIT];
		end
	end

	// [R16] [R17] reset to zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign cpu_rdata              = s.rdata;
	assign unit_a_timer_output    = s.pin[0];
	assign unit_b_timer_output    = s.pin[1];
	assign unit_a_timer_output_en = s.oe[0];
	assign unit_b_timer_output_en = s.oe[1];
	assign unit_a_match_irq       = s.irq[0];
	assign unit_b_match_irq       = s.irq[1];

	default clocking dtc_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_count_step;
		(s.cnt[0] != $past(s.cnt[0])) |-> (s.cnt[0] == dtc_step($past(s.cnt[0]))) || (s.cnt[0] == DTC_CNT_ZERO);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count moved by other than one"); // [R1]

	property p_read_hold;
		hold[0] && !cpu_wr |=> (s.cnt[0] == $past(s.cnt[0])) && (cpu_rdata == $past(s.cnt[0]));
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("count moved during read"); // [R2]

	property p_stop_clears;
		!en[0] |-> s.cnt[0] == DTC_CNT_ZERO;
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("stopped count not zero"); // [R3]

	property p_casc_stop;
		cascade && !en[0] |=> s.cnt[1] == DTC_CNT_ZERO;
	endproperty
	a_casc_stop: assert property (p_casc_stop) else $error("upper count not cleared on stop"); // [R4]

	property p_pwm_no_irq;
		eff[0] && pwm[0] |=> !unit_a_match_irq;
	endproperty
	a_pwm_no_irq: assert property (p_pwm_no_irq) else $error("match pulse in PWM mode"); // [R5]

	property p_pwm_no_irq_b;
		eff[1] && pwm[1] |=> !unit_b_match_irq;
	endproperty
	a_pwm_no_irq_b: assert property (p_pwm_no_irq_b) else $error("unit B match pulse in PWM mode"); // [R5]

	property p_halt;
		!en[0] ##1 !en[0] |-> !tick_raw[0];
	endproperty
	a_halt: assert property (p_halt) else $error("count tick while stopped"); // [R8]

	property p_ff_clear;
		cpu_wr && cpu_addr == DTC_MODE_ADDR[0] && cpu_wdata[DTC_SET_BIT:DTC_CLR_BIT] == DTC_FF_CLR |=> !s.tff[0];
	endproperty
	a_ff_clear: assert property (p_ff_clear) else $error("output flop not cleared"); // [R11]

	property p_ff_read;
		cpu_rd && cpu_addr == DTC_MODE_ADDR[0] |=> !cpu_rdata[DTC_SET_BIT] && !cpu_rdata[DTC_CLR_BIT];
	endproperty
	a_ff_read: assert property (p_ff_read) else $error("set or clear bit read as one"); // [R12]

	property p_pwm_stop;
		pwm[0] && !en[0] && !cpu_wr |=> unit_a_timer_output == s.mode[0][DTC_INV_BIT];
	endproperty
	a_pwm_stop: assert property (p_pwm_stop) else $error("stopped PWM output active"); // [R15]

	property p_pwm_stop_wr;
		cpu_wr && cpu_addr == DTC_MODE_ADDR[1] && pwm[1] && !cpu_wdata[DTC_EN_BIT]
			&& cpu_wdata[DTC_SET_BIT:DTC_CLR_BIT] == DTC_FF_KEEP
			|=> unit_b_timer_output == (s.mode[1][DTC_PWM_BIT] & s.mode[1][DTC_INV_BIT]);
	endproperty
	a_pwm_stop_wr: assert property (p_pwm_stop_wr) else $error("PWM output active after stop write"); // [R15]

	property p_csel_read;
		cpu_rd && cpu_addr == DTC_CSEL_ADDR[0] |=> (cpu_rdata & ~DTC_CSEL_MASK) == DTC_RST_BYTE;
	endproperty
	a_csel_read: assert property (p_csel_read) else $error("clock select upper bits not zero"); // [R19]

	property p_interval_match;
		eff[0] && !pwm[0] && !cascade && match[0] && !cpu_wr |=> unit_a_match_irq && s.cnt[0] == DTC_CNT_ZERO;
	endproperty
	a_interval_match: assert property (p_interval_match) else $error("interval match missed"); // [R21]

	property p_casc_match;
		eff[0] && cascade && !pwm[0] && both && !cpu_wr |=> unit_a_match_irq && s.cnt[0] == DTC_CNT_ZERO && s.cnt[1] == DTC_CNT_ZERO;
	endproperty
	a_casc_match: assert property (p_casc_match) else $error("16-bit match missed"); // [R24]

	property p_toggle;
		eff[0] && !pwm[0] && !cascade && inv[0] && match[0] && !cpu_wr |=> s.tff[0] != $past(s.tff[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("output did not toggle on match"); // [R25]

	c_interval_irq: cover property (eff[0] && !cascade && match[0] ##1 unit_a_match_irq);
	c_casc_irq: cover property (cascade && eff[0] && both ##1 unit_a_match_irq);
	c_pwm_active: cover property (pwm[0] && en[0] ##1 s.tff[0] ##1 !s.tff[0]);
	c_read_hold: cover property (hold[0] && raw[0]);
endmodule
`default_nettype wire

//--- verif/dtc_timer_tb.sv
// Purpose: self-checking bench for the dual 8-bit timer/counter block
// Assumes: cpu_rdata is valid the cycle after the read strobe
// Notes:   covers dividers, interval, square wave, PWM, cascade and event counting
`default_nettype none
module dtc_timer_tb
	import dtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk;
	logic        rst_n;
	logic [15:0] cpu_addr;
	logic        cpu_wr;
	logic        cpu_rd;
	logic [7:0]  cpu_wdata;
	logic [7:0]  cpu_rdata;
	logic        ev_a;
	logic        ev_b;
	logic        out_a;
	logic        out_a_en;
	logic        out_b;
	logic        out_b_en;
	logic        irq_a;
	logic        irq_b;
	logic        o1;
	logic        irq_b_seen;
	logic [7:0]  rd_val;
	int          cyc;
	int          num_errors;
	int          compares;
	int          divs [8] = '{0, 0, 4, 8, 16, 32, 128, 512};

	dtc_timer dut (
		.clk                    (clk),
		.rst_n                  (rst_n),
		.cpu_addr               (cpu_addr),
		.cpu_wr                 (cpu_wr),
		.cpu_rd                 (cpu_rd),
		.cpu_wdata              (cpu_wdata),
		.cpu_rdata              (cpu_rdata),
		.unit_a_event_input     (ev_a),
		.unit_b_event_input     (ev_b),
		.unit_a_timer_output    (out_a),
		.unit_a_timer_output_en (out_a_en),
		.unit_b_timer_output    (out_b),
		.unit_b_timer_output_en (out_b_en),
		.unit_a_match_irq       (irq_a),
		.unit_b_match_irq       (irq_b)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic summarize();
		$display("compares=%0d errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp, input string msg);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %b exp %b", $time, msg, got, exp);
		end
	endtask

	task automatic chk_cyc(input int got, input int lo, input int hi, input string msg);
		compares++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("[ERR] %0t %s got %0d exp %0d..%0d", $time, msg, got, lo, hi);
		end
	endtask

	task automatic settle();
		@(posedge clk);
		#1;
	endtask

	// cpu port: strobe for one cycle, hold address and data with it
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		cpu_addr  <= a;
		cpu_wdata <= d;
		cpu_wr    <= 1'b1;
		@(posedge clk);
		cpu_wr    <= 1'b0;
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string msg);
		@(posedge clk);
		cpu_addr <= a;
		cpu_rd   <= 1'b1;
		@(posedge clk);
		cpu_rd   <= 1'b0;
		settle();
		rd_val = cpu_rdata;
		chk8(rd_val, exp, msg);
	endtask

	task automatic timeout(input string msg);
		num_errors++;
		$display("[ERR] %0t wait ran out: %s", $time, msg);
		summarize();
	endtask

	// cycles until the chosen unit's match pulse is seen
	task automatic wait_irq(input int u, input int max, output int n);
		n = 0;
		do begin
			settle();
			n++;
		end while (((u == 0) ? irq_a : irq_b) !== 1'b1 && n < max);
		if (n >= max) timeout("match pulse");
	endtask

	// cycles until unit B's pin reaches a level; flags any unit B match pulse
	task automatic wait_out_b(input logic lvl, input int max, output int n);
		n = 0;
		do begin
			settle();
			n++;
			if (irq_b === 1'b1) irq_b_seen = 1'b1;
		end while (out_b !== lvl && n < max);
		if (n >= max) timeout("pin level");
	endtask

	initial begin
		rst_n      = 1'b0;
		cpu_addr   = 16'h0000;
		cpu_wr     = 1'b0;
		cpu_rd     = 1'b0;
		cpu_wdata  = 8'h00;
		ev_a       = 1'b1;
		ev_b       = 1'b0;
		irq_b_seen = 1'b0;
		num_errors = 0;
		compares   = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			rdchk(DTC_MODE_ADDR[i], DTC_RST_BYTE, "mode reset");
			rdchk(DTC_CSEL_ADDR[i], DTC_RST_BYTE, "clock select reset");
			rdchk(DTC_CNT_ADDR[i], DTC_CNT_ZERO, "count reset");
		end
		rdchk(16'hFF70, 8'h00, "unmapped read");
		// register access
		wr(DTC_CSEL_ADDR[0], 8'hFF);
		rdchk(DTC_CSEL_ADDR[0], 8'h07, "clock select upper bits");
		wr(DTC_CNT_ADDR[0], 8'h55);
		rdchk(DTC_CNT_ADDR[0], DTC_CNT_ZERO, "count not writable");
		wr(DTC_CMP_ADDR[0], 8'h5A);
		wr(DTC_CMP_ADDR[1], 8'hA5);
		rdchk(DTC_CMP_ADDR[0], 8'h5A, "compare a");
		rdchk(DTC_CMP_ADDR[1], 8'hA5, "compare b");
		wr(DTC_MODE_ADDR[0], 8'hFF);
		rdchk(DTC_MODE_ADDR[0], 8'hC3, "mode a readback");
		wr(DTC_MODE_ADDR[0], 8'h00);
		wr(DTC_MODE_ADDR[1], 8'h1C);
		rdchk(DTC_MODE_ADDR[1], 8'h10, "mode b readback");
		wr(DTC_MODE_ADDR[1], 8'h00);
		// output flop set and clear
		wr(DTC_MODE_ADDR[0], 8'h09);
		settle();
		chk_pin(out_a, 1'b1, "flop set");
		chk_pin(out_a_en, 1'b1, "pin driver on");
		wr(DTC_MODE_ADDR[0], 8'h05);
		settle();
		chk_pin(out_a, 1'b0, "flop clear");
		rdchk(DTC_MODE_ADDR[0], 8'h01, "set clear read zero");
		wr(DTC_MODE_ADDR[0], 8'h00);
		settle();
		chk_pin(out_a_en, 1'b0, "pin driver off");
		// every divider, compare 00 gives one match per tick
		wr(DTC_CMP_ADDR[0], 8'h00);
		for (int k = 2; k < 8; k++) begin
			wr(DTC_CSEL_ADDR[0], 8'(k));
			wr(DTC_MODE_ADDR[0], 8'h80);
			wait_irq(0, 1200, cyc);
			wait_irq(0, 1200, cyc);
			chk_cyc(cyc, divs[k], divs[k], "divider period");
			wr(DTC_MODE_ADDR[0], 8'h00);
		end
		// interval with square wave
		wr(DTC_CMP_ADDR[0], 8'h02);
		wr(DTC_CSEL_ADDR[0], {5'h00, DTC_CS_DIV4});
		wr(DTC_MODE_ADDR[0], 8'h83);
		wait_irq(0, 100, cyc);
		o1 = out_a;
		wait_irq(0, 100, cyc);
		chk_cyc(cyc, 12, 12, "interval period");
		chk_pin(out_a, ~o1, "square wave toggle");
		wr(DTC_MODE_ADDR[0], 8'h00);
		rdchk(DTC_CNT_ADDR[0], DTC_CNT_ZERO, "count after stop");
		// unit B interval, compare 01 gives two ticks of 4 cycles
		wr(DTC_CSEL_ADDR[1], {5'h00, DTC_CS_DIV4});
		wr(DTC_CMP_ADDR[1], 8'h01);
		wr(DTC_MODE_ADDR[1], 8'h80);
		wait_irq(1, 100, cyc);
		wait_irq(1, 100, cyc);
		chk_cyc(cyc, 8, 8, "unit b interval period");
		wr(DTC_MODE_ADDR[1], 8'h00);
		// pwm on unit B, active high, width 0x81 ticks of 4 cycles
		wr(DTC_CMP_ADDR[1], 8'h80);
		wr(DTC_MODE_ADDR[1], 8'hC1);
		wait_out_b(1'b1, 1200, cyc);
		chk_cyc(cyc, 1020, 1035, "pwm first active");
		wait_out_b(1'b0, 600, cyc);
		chk_cyc(cyc, 516, 516, "pwm active width");
		wait_out_b(1'b1, 1200, cyc);
		wr(DTC_MODE_ADDR[1], 8'h00);
		settle();
		chk_pin(out_b, 1'b0, "pwm stop level");
		chk_pin(irq_b_seen, 1'b0, "no match pulse in pwm");
		wr(DTC_MODE_ADDR[1], 8'hC3);
		repeat (20) @(posedge clk);
		#1;
		chk_pin(out_b, 1'b1, "active low idle");
		chk_pin(out_b_en, 1'b1, "pin driver b on");
		wr(DTC_MODE_ADDR[1], 8'h00);
		// cascade: 16-bit compare 0x0103, upper unit started first
		wr(DTC_CMP_ADDR[0], 8'h03);
		wr(DTC_CMP_ADDR[1], 8'h01);
		wr(DTC_MODE_ADDR[1], 8'h90);
		wr(DTC_MODE_ADDR[0], 8'h80);
		wait_irq(0, 1200, cyc);
		wait_irq(0, 1200, cyc);
		chk_cyc(cyc, 1040, 1040, "cascade period");
		repeat (1030) @(posedge clk);
		rdchk(DTC_CNT_ADDR[1], DTC_CNT_ONE, "upper byte");
		wr(DTC_MODE_ADDR[0], 8'h00);
		rdchk(DTC_CNT_ADDR[1], DTC_CNT_ZERO, "cascade stop");
		wr(DTC_MODE_ADDR[1], 8'h00);
		// event counting: A on falling edges, B on rising edges
		wr(DTC_CSEL_ADDR[0], {5'h00, DTC_CS_FALL});
		wr(DTC_CSEL_ADDR[1], {5'h00, DTC_CS_RISE});
		wr(DTC_CMP_ADDR[0], DTC_CNT_MAX);
		wr(DTC_CMP_ADDR[1], DTC_CNT_MAX);
		wr(DTC_MODE_ADDR[0], 8'h80);
		wr(DTC_MODE_ADDR[1], 8'h80);
		for (int p = 0; p < 5; p++) begin
			repeat (8) @(posedge clk);
			ev_b <= 1'b1;
			if (p < 3) ev_a <= 1'b0;
			repeat (8) @(posedge clk);
			ev_b <= 1'b0;
			ev_a <= 1'b1;
		end
		repeat (10) @(posedge clk);
		rdchk(DTC_CNT_ADDR[0], 8'h03, "falling edge count");
		rdchk(DTC_CNT_ADDR[1], 8'h05, "rising edge count");
		summarize();
	end
endmodule
`default_nettype wire
